// file: include/gptc_map.vh
// Address map, command codes and reset values of the timer/counter.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef GPTC_MAP_VH
`define GPTC_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define GPTC_OFS_SUMMARY 8'h80
`define GPTC_OFS_TIMER 8'h84

// ----------------------------------------------------------------
// Field positions in the timer word and the summary word
// ----------------------------------------------------------------
`define GPTC_CMD_LSB 0
`define GPTC_CMD_MSB 3
`define GPTC_CNT_LSB 16
`define GPTC_CNT_MSB 31
`define GPTC_CODE_LSB 8
`define GPTC_CODE_MSB 10

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define GPTC_CMD_IRQ_EN 4'h1
`define GPTC_CMD_IRQ_DIS 4'h2
`define GPTC_CMD_ONESHOT 4'h3
`define GPTC_CMD_RETRIG 4'h4
`define GPTC_CMD_CLK_INT 4'h5
`define GPTC_CMD_CLK_EXT 4'h6
`define GPTC_CMD_ROUTE 4'h7
`define GPTC_CMD_DEROUTE 4'h8
`define GPTC_CMD_START 4'h9
`define GPTC_CMD_RESET 4'ha
`define GPTC_CMD_STOP 4'hb

// ----------------------------------------------------------------
// Read values and reset values
// ----------------------------------------------------------------
`define GPTC_STAT_PEND 8'h01
`define GPTC_STAT_NONE 8'h00
`define GPTC_CODE_TIMER 3'h7
`define GPTC_CODE_NONE 3'h0
`define GPTC_CNT_RST 16'h0000

`endif

// file: src/gptc_timer.v
// General-purpose 16-bit timer/counter with AHB-Lite register access.
// Assumes synchronous inputs on hclk; hclk serves as the internal clock.
`timescale 1ns/1ps
`include "gptc_map.vh"

module gptc_timer (
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire external_timer_clock_pin,
    input wire pin_level_control,
    input wire pin_direction_select,
    output reg multipurpose_pin_zero_o,
    output reg multipurpose_pin_zero_oe,
    output reg timer_out_q,
    output reg [2:0] interrupt_source_code_byte
);

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function [15:0] phase_high;
        input [15:0] n;
        begin
            phase_high = {1'b0, n[15:1]};
        end
    endfunction

    function [15:0] phase_low;
        input [15:0] n;
        begin
            phase_low = n - {1'b0, n[15:1]};
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [15:0] count_n_q;
    reg [15:0] count_n_d;
    reg [15:0] tick_cnt_q;
    reg [15:0] tick_cnt_d;
    reg irq_en_q;
    reg irq_en_d;
    reg one_shot_q;
    reg one_shot_d;
    reg clk_ext_q;
    reg clk_ext_d;
    reg routed_q;
    reg routed_d;
    reg pend_q;
    reg pend_d;
    reg out_d;
    reg ext_prev_q;
    reg tick;
    reg fire;
    reg [15:0] cnt_next;
    reg [3:0] cmd;
    reg cmd_ok;
    reg [31:0] rd_mux;
    wire addr_phase;
    wire rd_cmd;
    wire wr_timer;

    assign addr_phase = hsel & htrans[1] & hready;
    assign rd_cmd = addr_phase & ~hwrite & (haddr[7:0] == `GPTC_OFS_TIMER);
    assign wr_timer = wr_pend_q & (wr_addr_q == `GPTC_OFS_TIMER);

    // ------------------------------------------------------------
    // Counting and command decode
    // ------------------------------------------------------------
    always @* begin
        state_d = state_q;
        count_n_d = count_n_q;
        tick_cnt_d = tick_cnt_q;
        irq_en_d = irq_en_q;
        one_shot_d = one_shot_q;
        clk_ext_d = clk_ext_q;
        routed_d = routed_q;
        out_d = timer_out_q;
        fire = 1'b0;
        tick = clk_ext_q ? (external_timer_clock_pin & ~ext_prev_q) : 1'b1;
        cnt_next = tick_cnt_q + 16'h0001;
        cmd = wr_timer ? hwdata[`GPTC_CMD_MSB:`GPTC_CMD_LSB] : 4'h0;
        // Running one-shot and done timers take only start, stop and reset; running retriggerable timers take only stop and reset
        case (state_q)
            ST_IDLE: cmd_ok = 1'b1;
            ST_RUN: cmd_ok = one_shot_q ? (cmd == `GPTC_CMD_START) | (cmd == `GPTC_CMD_STOP)
                | (cmd == `GPTC_CMD_RESET)
                : (cmd == `GPTC_CMD_STOP) | (cmd == `GPTC_CMD_RESET);
            ST_DONE: cmd_ok = (cmd == `GPTC_CMD_START) | (cmd == `GPTC_CMD_STOP)
                | (cmd == `GPTC_CMD_RESET);
            default: cmd_ok = 1'b0;
        endcase
        if (wr_timer && (state_q == ST_IDLE)) begin
            count_n_d = hwdata[`GPTC_CNT_MSB:`GPTC_CNT_LSB];
        end
        if ((state_q == ST_RUN) && tick) begin
            if (one_shot_q) begin
                if (cnt_next == count_n_q) begin
                    out_d = 1'b0;
                    fire = 1'b1;
                    state_d = ST_DONE;
                    tick_cnt_d = 16'h0000;
                end else begin
                    tick_cnt_d = cnt_next;
                end
            end else if (timer_out_q) begin
                if (cnt_next == phase_high(count_n_q)) begin
                    out_d = 1'b0;
                    tick_cnt_d = 16'h0000;
                end else begin
                    tick_cnt_d = cnt_next;
                end
            end else begin
                if (cnt_next == phase_low(count_n_q)) begin
                    out_d = 1'b1;
                    fire = 1'b1;
                    tick_cnt_d = 16'h0000;
                end else begin
                    tick_cnt_d = cnt_next;
                end
            end
        end
        if (cmd_ok) begin
            case (cmd)
                `GPTC_CMD_IRQ_EN: irq_en_d = 1'b1;
                `GPTC_CMD_IRQ_DIS: irq_en_d = 1'b0;
                `GPTC_CMD_ONESHOT: one_shot_d = 1'b1;
                `GPTC_CMD_RETRIG: one_shot_d = 1'b0;
                `GPTC_CMD_CLK_INT: clk_ext_d = 1'b0;
                `GPTC_CMD_CLK_EXT: clk_ext_d = 1'b1;
                `GPTC_CMD_ROUTE: routed_d = 1'b1;
                `GPTC_CMD_DEROUTE: routed_d = 1'b0;
                `GPTC_CMD_START: begin
                    if (state_q != ST_DONE) begin
                        state_d = ST_RUN;
                        tick_cnt_d = 16'h0000;
                        out_d = 1'b1;
                    end
                end
                `GPTC_CMD_STOP: begin
                    state_d = ST_IDLE;
                    out_d = 1'b1;
                    tick_cnt_d = 16'h0000;
                end
                `GPTC_CMD_RESET: begin
                    state_d = ST_IDLE;
                    irq_en_d = 1'b0;
                    one_shot_d = 1'b0;
                    clk_ext_d = 1'b0;
                    routed_d = 1'b0;
                    out_d = 1'b1;
                    tick_cnt_d = 16'h0000;
                end
                default: state_d = state_d;
            endcase
        end
        // Set wins over a clearing read; stop and start leave it alone
        if (fire) begin
            pend_d = 1'b1;
        end else if (rd_cmd || (cmd_ok && (cmd == `GPTC_CMD_RESET))) begin
            pend_d = 1'b0;
        end else begin
            pend_d = pend_q;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @* begin
        rd_mux = 32'h0000_0000;
        if (haddr[7:0] == `GPTC_OFS_TIMER) begin
            rd_mux[`GPTC_CNT_MSB:`GPTC_CNT_LSB] = count_n_q;
            rd_mux[7:0] = (irq_en_q & pend_q) ? `GPTC_STAT_PEND : `GPTC_STAT_NONE;
        end else if (haddr[7:0] == `GPTC_OFS_SUMMARY) begin
            rd_mux[`GPTC_CODE_MSB:`GPTC_CODE_LSB] = interrupt_source_code_byte;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            state_q <= ST_IDLE;
            count_n_q <= `GPTC_CNT_RST;
            tick_cnt_q <= 16'h0000;
            irq_en_q <= 1'b0;
            one_shot_q <= 1'b0;
            clk_ext_q <= 1'b0;
            routed_q <= 1'b0;
            pend_q <= 1'b0;
            timer_out_q <= 1'b1;
            ext_prev_q <= 1'b0;
            multipurpose_pin_zero_o <= 1'b0;
            multipurpose_pin_zero_oe <= 1'b0;
            interrupt_source_code_byte <= `GPTC_CODE_NONE;
        end else if (clk_en) begin
            wr_pend_q <= addr_phase & hwrite;
            wr_addr_q <= haddr[7:0];
            if (addr_phase && !hwrite) begin
                hrdata <= rd_mux;
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            state_q <= state_d;
            count_n_q <= count_n_d;
            tick_cnt_q <= tick_cnt_d;
            irq_en_q <= irq_en_d;
            one_shot_q <= one_shot_d;
            clk_ext_q <= clk_ext_d;
            routed_q <= routed_d;
            pend_q <= pend_d;
            timer_out_q <= out_d;
            ext_prev_q <= external_timer_clock_pin;
            if (routed_d) begin
                multipurpose_pin_zero_o <= out_d;
                multipurpose_pin_zero_oe <= 1'b1;
            end else begin
                multipurpose_pin_zero_o <= pin_level_control;
                multipurpose_pin_zero_oe <= pin_direction_select;
            end
            interrupt_source_code_byte <= (irq_en_d & pend_d) ?
                `GPTC_CODE_TIMER : `GPTC_CODE_NONE;
        end
    end

endmodule // gptc_timer

// file: test/gptc_timer_sva.sv
// Checker bound to the timer/counter top ports.
// Assumes clk_en held high and single-word AHB-Lite transfers.
`timescale 1ns/1ps
module gptc_sva (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire pin_level_control,
    input wire pin_direction_select,
    input wire multipurpose_pin_zero_o,
    input wire multipurpose_pin_zero_oe,
    input wire timer_out_q,
    input wire [2:0] interrupt_source_code_byte
);
    wire ap = hsel & htrans[1] & hready;
    wire [2:0] cd = interrupt_source_code_byte;
    wire po = multipurpose_pin_zero_o;
    wire poe = multipurpose_pin_zero_oe;
    reg [2:0] dp_q;
    // Data phase flags: summary read, timer read, timer write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) dp_q <= 3'h0;
        else dp_q <= {ap & !hwrite & haddr[7:0] == 8'h80, ap & !hwrite & haddr[7:0] == 8'h84,
            ap & hwrite & haddr[7:0] == 8'h84};
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_code; cd == 3'h0 || cd == 3'h7; endproperty
    a_code: assert property (p_code) else $error("bad source code");
    property p_route; $past(hresetn) && (poe != $past(pin_direction_select) ||
        po != $past(pin_level_control)) |-> poe && po == timer_out_q; endproperty
    a_route: assert property (p_route) else $error("pin not under timer");
    property p_cause; $rose(cd[0]) |-> timer_out_q != $past(timer_out_q) ||
        $past(dp_q[0]) || $past(dp_q[0], 2); endproperty
    a_cause: assert property (p_cause) else $error("interrupt without cause");
    property p_stop; dp_q[0] && hwdata[3:0] == 4'hb |=> timer_out_q; endproperty
    a_stop: assert property (p_stop) else $error("stop left output low");
    property p_rcmd; dp_q[0] && hwdata[3:0] == 4'ha |=> timer_out_q ##1 cd == 3'h0; endproperty
    a_rcmd: assert property (p_rcmd) else $error("reset command failed");
    property p_rel; $rose(hresetn) |-> timer_out_q && cd == 3'h0; endproperty
    a_rel: assert property (p_rel) else $error("bad state after reset");
    property p_rdfmt; dp_q[1] |-> hrdata[15:1] == 15'h0; endproperty
    a_rdfmt: assert property (p_rdfmt) else $error("status not 0 or 1");
    property p_sum; dp_q[2] |-> hrdata[31:11] == 21'h0 && hrdata[7:0] == 8'h0; endproperty
    a_sum: assert property (p_sum) else $error("summary bits outside code");
    c_start: cover property (dp_q[0] && hwdata[3:0] == 4'h9);
    c_irq: cover property ($rose(cd[0]));
    c_route: cover property (poe && !pin_direction_select);
endmodule // gptc_sva
bind gptc_timer gptc_sva u_sva (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .pin_level_control(pin_level_control),
    .pin_direction_select(pin_direction_select),
    .multipurpose_pin_zero_o(multipurpose_pin_zero_o),
    .multipurpose_pin_zero_oe(multipurpose_pin_zero_oe),
    .timer_out_q(timer_out_q),
    .interrupt_source_code_byte(interrupt_source_code_byte)
);

// file: test/gptc_ext_clk.sv
// Model of the external timer clock source.
// Assumes the bench clock; the pin stands low while run is low.
`timescale 1ns/1ps
module gptc_ext_clk (
    input wire hclk,
    input wire run,
    output wire pin
);
    reg [1:0] div_q = 2'h0;
    always @(posedge hclk) begin
        div_q <= run ? div_q + 2'h1 : 2'h0;
    end
    assign pin = div_q[1];
endmodule // gptc_ext_clk

// file: test/gptc_timer_tb.sv
// Self-checking bench for the timer/counter over AHB-Lite.
// Assumes the checker is bound and the clock model drives the timer pin.
`timescale 1ns/1ps
module gptc_timer_tb;
    reg hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, ext_run = 1'h0;
    reg [1:0] htrans = 2'h0;
    reg pin_lvl = 1'h0, pin_dir = 1'h0;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hrdy, hrsp, ext, po, poe, tq;
    integer n_mismatch = 0, n_tests = 0, k;
    gptc_timer dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hrdata(hrdata), .hreadyout(hrdy), .hresp(hrsp), .external_timer_clock_pin(ext),
        .pin_level_control(pin_lvl), .pin_direction_select(pin_dir),
        .multipurpose_pin_zero_o(po),
        .multipurpose_pin_zero_oe(poe), .timer_out_q(tq), .interrupt_source_code_byte());
    gptc_ext_clk u_ext (.hclk(hclk), .run(ext_run), .pin(ext));
    initial forever #12.5 hclk = ~hclk;
    task chk(input [31:0] s, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (s !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t seen %h exp %h", $time, s, e);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge hclk);
            hwrite <= w;
            haddr <= {24'h0, a};
            htrans <= 2'h2;
            @(posedge hclk);
            while (hrdy !== 1'h1) @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (hrdy !== 1'h1) @(posedge hclk);
            chk(hrsp, 32'h0);
            if (!w) chk(hrdata, d);
            #1;
        end
    endtask
    task wr(input [31:0] d); bus(1'h1, 8'h84, d); endtask
    task rd(input [7:0] a, input [31:0] e); bus(1'h0, a, e); endtask
    // Counts cycles until the timer output leaves the given level
    task meas(input lv, input integer e);
        begin
            k = 0;
            do begin
                @(posedge hclk);
                #1;
                k = k + 1;
            end while (tq === lv && k < 1000);
            chk(k, e);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        hsel <= 1'h1;
        rd(8'h84, 32'h0);
        rd(8'h40, 32'h0);
        wr(32'h00050001);
        wr(32'h00050004);
        rd(8'h84, 32'h00050000);
        wr(32'h00050009);
        meas(1'h1, 2);
        meas(1'h0, 3);
        wr(32'h00090009);
        wr(32'h0005000b);
        chk(tq, 1'h1);
        rd(8'h80, 32'h00000700);
        rd(8'h84, 32'h00050001);
        rd(8'h84, 32'h00050000);
        wr(32'h00200003);
        wr(32'h00200009);
        wr(32'h00070002);
        wr(32'h00200009);
        meas(1'h1, 32);
        wr(32'h00200009);
        repeat (40) @(posedge hclk);
        #1;
        chk(tq, 1'h0);
        rd(8'h84, 32'h00200001);
        wr(32'h0020000b);
        chk(tq, 1'h1);
        wr(32'h00200009);
        meas(1'h1, 32);
        wr(32'h0020000a);
        wr(32'h00200001);
        rd(8'h84, 32'h00200000);
        wr(32'h00200007);
        chk({po, poe}, 2'h3);
        wr(32'h00200008);
        chk({po, poe}, 2'h0);
        @(posedge hclk);
        pin_lvl <= 1'h1;
        repeat (2) @(posedge hclk);
        #1;
        chk({po, poe}, 2'h2);
        wr(32'h00200009);
        meas(1'h1, 16);
        wr(32'h0020000b);
        wr(32'h00040003);
        wr(32'h00040006);
        wr(32'h00040009);
        repeat (20) @(posedge hclk);
        ext_run <= 1'h1;
        #1;
        chk(tq, 1'h1);
        repeat (40) @(posedge hclk);
        ext_run <= 1'h0;
        #1;
        chk(tq, 1'h0);
        wr(32'h0004000b);
        wr(32'h00040005);
        wr(32'h00040002);
        rd(8'h84, 32'h00040000);
        wrap_up;
    end
endmodule // gptc_timer_tb
